/* File: shared/bcu_regs.svh */
// register map, field positions and opcode constants of the branch unit
`ifndef BCU_REGS_SVH
`define BCU_REGS_SVH
`define BCU_OFF_CTRL      8'h00
`define BCU_OFF_STATUS    8'h04
`define BCU_OFF_TAKEN_CNT 8'h08
`define BCU_OFF_LAST_TGT  8'h0c
`define BCU_CTRL_RESET    2'h1
`define BCU_CTRL_EN_BIT   0
`define BCU_CTRL_LATE_BIT 1
`define BCU_STAT_SLOT_BIT 0
`define BCU_STAT_TAKN_BIT 1
`define BCU_STAT_EXC_BIT  2
`define BCU_RESP_OKAY     2'h0
`define BCU_RESP_SLVERR   2'h2
`define BCU_MAJ_BCC       5'h00
`define BCU_MAJ_BBIT      5'h01
`define BCU_BBIT_CLR      4'he
`define BCU_BBIT_SET      4'hf
`define BCU_S_BEQ         7'h79
`define BCU_S_BNE         7'h7a
`define BCU_S_BCC         7'h7b
`define BCU_CC_EQ         5'h01
`define BCU_CC_NE         5'h02
`define BCU_CC_LO         5'h05
`define BCU_CC_HS         5'h06
`define BCU_CC_GT         5'h09
`define BCU_CC_GE         5'h0a
`define BCU_CC_LT         5'h0b
`define BCU_CC_LE         5'h0c
`define BCU_CC_HI         5'h0d
`define BCU_CC_LS         5'h0e
`define BCU_CC_PNZ        5'h0f
`define BCU_W_S21         21
`define BCU_W_S25         25
`define BCU_W_S9          9
`define BCU_W_S10         10
`define BCU_W_S7          7
`endif

/* File: shared/bcu_pkg.sv */
// types shared by the branch unit modules
package bcu_pkg;
  typedef struct packed {
    logic z;
    logic n;
    logic c;
    logic v;
  } bcu_flags_t;
  typedef struct packed {
    logic jump;
    logic loop_setup;
    logic int_return;
    logic long_imm;
  } bcu_slot_cls_t;
  typedef struct packed {
    logic [31:0]   insn;
    logic          is16;
    logic [31:0]   pc;
    logic [31:0]   first_source_operand;
    logic [31:0]   second_source_operand;
    bcu_flags_t    flags;
    bcu_slot_cls_t cls;
  } bcu_issue_t;
  typedef struct packed {
    logic        valid;
    logic        taken;
    logic [31:0] target;
    logic        kill_next;
    logic        kill_beyond;
    logic        exec_slot;
    logic        seq_exc;
  } bcu_result_t;
  typedef enum logic [2:0] {
    BK_NONE, BK_BCC, BK_FAR, BK_BIT_CLR, BK_BIT_SET, BK_SHORT
  } bcu_kind_t;
  typedef enum logic {ST_RUN, ST_SLOT} bcu_state_t;
endpackage : bcu_pkg

/* File: verilog/bcu_cond_eval.sv */
// condition code evaluation against the status flags
`timescale 1ns/1ps
`default_nettype none
`include "bcu_regs.svh"
module bcu_cond_eval (
  input  wire logic [4:0]        cond,  // 5-bit condition field
  input  wire bcu_pkg::bcu_flags_t flags, // z n c v
  output logic                   hit    // condition true
);
  // ****************************************
  // condition table
  // ****************************************
  always_comb begin
    case (cond)
      5'h00:      hit = 1'b1;
      `BCU_CC_EQ: hit = flags.z;
      `BCU_CC_NE: hit = !flags.z;
      5'h03:      hit = !flags.n;
      5'h04:      hit = flags.n;
      `BCU_CC_LO: hit = flags.c;
      `BCU_CC_HS: hit = !flags.c;
      5'h07:      hit = flags.v;
      5'h08:      hit = !flags.v;
      `BCU_CC_GT: hit = (flags.n == flags.v) && !flags.z;
      `BCU_CC_GE: hit = (flags.n == flags.v);
      `BCU_CC_LT: hit = (flags.n != flags.v);
      `BCU_CC_LE: hit = flags.z || (flags.n != flags.v);
      `BCU_CC_HI: hit = !flags.c && !flags.z;
      `BCU_CC_LS: hit = flags.c || flags.z;
      `BCU_CC_PNZ: hit = !flags.n && !flags.z;
      default:    hit = 1'b0;  // extension codes never taken
    endcase
  end
endmodule : bcu_cond_eval
`default_nettype wire

/* File: verilog/bcu_target_gen.sv */
// branch target from the word-aligned pc and a displacement
`timescale 1ns/1ps
`default_nettype none
module bcu_target_gen (
  input  wire logic [31:0] pc,     // address of the branch
  input  wire logic [31:0] disp,   // sign-extended byte displacement
  output logic      [31:0] target  // halfword-aligned target
);
  // ****************************************
  // target adder
  // ****************************************
  logic [31:0] aligned_pc;
  assign aligned_pc = {pc[31:2], 2'b00};
  // pc bits 1:0 are cleared, so bit 1 of the target comes from the displacement
  assign target = aligned_pc + disp;
endmodule : bcu_target_gen
`default_nettype wire

/* File: verilog/bcu_branch_unit.sv */
// branch condition unit: decode, evaluate, redirect, slot check, axi regs
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bcu_regs.svh"
module bcu_branch_unit #(
  parameter int ADDR_W = 8  // axi address width
) (
  input  wire logic              CLK,           // core clock
  input  wire logic              RESET,         // sync reset, high
  input  wire logic              ISSUE_VALID,   // instruction issued
  input  wire bcu_pkg::bcu_issue_t ISSUE,       // instruction and operands
  output bcu_pkg::bcu_result_t   RESULT,        // branch outcome
  output logic                   FLAG_WRITE,    // flag update strobe
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,  // write address
  input  wire logic              S_AXI_AWVALID, // write address valid
  output logic                   S_AXI_AWREADY, // write address ready
  input  wire logic [31:0]       S_AXI_WDATA,   // write data
  input  wire logic [3:0]        S_AXI_WSTRB,   // byte enables
  input  wire logic              S_AXI_WVALID,  // write data valid
  output logic                   S_AXI_WREADY,  // write data ready
  output logic [1:0]             S_AXI_BRESP,   // write response
  output logic                   S_AXI_BVALID,  // write response valid
  input  wire logic              S_AXI_BREADY,  // write response ready
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,  // read address
  input  wire logic              S_AXI_ARVALID, // read address valid
  output logic                   S_AXI_ARREADY, // read address ready
  output logic [31:0]            S_AXI_RDATA,   // read data
  output logic [1:0]             S_AXI_RRESP,   // read response
  output logic                   S_AXI_RVALID,  // read data valid
  input  wire logic              S_AXI_RREADY   // read data ready
);
  // ****************************************
  // helpers
  // ****************************************
  // sign-extend the low w bits of raw
  function automatic logic [31:0] sext(input logic [31:0] raw,
                                       input int unsigned w);
    logic [31:0] sh;
    sh = 32'(32 - w);
    return 32'($signed(raw << sh) >>> sh);
  endfunction : sext

  // map the 3-bit short condition onto the 5-bit code
  function automatic logic [4:0] short_cond(input logic [2:0] sel);
    case (sel)
      3'h0:    return `BCU_CC_GT;
      3'h1:    return `BCU_CC_GE;
      3'h2:    return `BCU_CC_LT;
      3'h3:    return `BCU_CC_LE;
      3'h4:    return `BCU_CC_HI;
      3'h5:    return `BCU_CC_HS;
      3'h6:    return `BCU_CC_LO;
      default: return `BCU_CC_LS;
    endcase
  endfunction : short_cond

  // ****************************************
  // decode
  // ****************************************
  bcu_pkg::bcu_kind_t kind;
  logic [4:0]         cond;
  logic [31:0]        disp;
  logic               delay;
  logic [31:0]        w;
  logic [15:0]        h;
  assign w = ISSUE.insn;
  assign h = ISSUE.insn[15:0];

  // field extraction for every branch form this unit owns
  always_comb begin
    kind  = bcu_pkg::BK_NONE;
    cond  = 5'h00;
    disp  = 32'h0;
    delay = 1'b0;
    if (ISSUE.is16) begin
      if (h[15:9] == `BCU_S_BEQ || h[15:9] == `BCU_S_BNE) begin
        kind = bcu_pkg::BK_SHORT;
        cond = (h[15:9] == `BCU_S_BEQ) ? `BCU_CC_EQ : `BCU_CC_NE;
        disp = sext({22'h0, h[8:0], 1'b0}, `BCU_W_S10);
      end else if (h[15:9] == `BCU_S_BCC) begin
        kind = bcu_pkg::BK_SHORT;
        cond = short_cond(h[8:6]);
        disp = sext({25'h0, h[5:0], 1'b0}, `BCU_W_S7);
      end
    end else if (w[31:27] == `BCU_MAJ_BCC) begin
      delay = w[5];
      if (!w[16]) begin
        kind = bcu_pkg::BK_BCC;
        cond = w[4:0];
        disp = sext({11'h0, w[15:6], w[26:17], 1'b0}, `BCU_W_S21);
      end else begin
        kind = bcu_pkg::BK_FAR;
        disp = sext({7'h0, w[3:0], w[15:6], w[26:17], 1'b0},
                    `BCU_W_S25);
      end
    end else if (w[31:27] == `BCU_MAJ_BBIT && w[16]) begin
      delay = w[5];
      disp  = sext({23'h0, w[15], w[23:17], 1'b0}, `BCU_W_S9);
      if (w[3:0] == `BCU_BBIT_CLR) begin
        kind = bcu_pkg::BK_BIT_CLR;
      end else if (w[3:0] == `BCU_BBIT_SET) begin
        kind = bcu_pkg::BK_BIT_SET;
      end
    end
  end

  // ****************************************
  // evaluation
  // ****************************************
  logic        cond_hit;
  logic        test_bit;
  logic        taken;
  logic [31:0] target;

  bcu_cond_eval u_cond (
    .cond  (cond),
    .flags (ISSUE.flags),
    .hit   (cond_hit)
  );

  bcu_target_gen u_tgt (
    .pc     (ISSUE.pc),
    .disp   (disp),
    .target (target)
  );

  // only the five low bits of the second operand select the bit
  assign test_bit = ISSUE.first_source_operand[ISSUE.second_source_operand[4:0]];

  // taken decision per branch kind
  always_comb begin
    case (kind)
      bcu_pkg::BK_BCC:     taken = cond_hit;
      bcu_pkg::BK_SHORT:   taken = cond_hit;
      bcu_pkg::BK_FAR:     taken = 1'b1;
      bcu_pkg::BK_BIT_CLR: taken = !test_bit;
      bcu_pkg::BK_BIT_SET: taken = test_bit;
      default:             taken = 1'b0;
    endcase
  end

  // ****************************************
  // control registers and slot tracking
  // ****************************************
  logic [1:0]          ctrl;
  bcu_pkg::bcu_state_t state;
  logic                slot_bad;
  logic                fire;
  logic                exc_sticky;
  logic                last_taken;
  logic [31:0]         taken_cnt;
  logic [31:0]         last_tgt;
  logic                exc_clr;

  assign fire = ISSUE_VALID && ctrl[`BCU_CTRL_EN_BIT];
  // an executed slot on the late variant may hold none of these
  assign slot_bad = (state == bcu_pkg::ST_SLOT) && ctrl[`BCU_CTRL_LATE_BIT]
                    && (kind != bcu_pkg::BK_NONE || ISSUE.cls.jump
                        || ISSUE.cls.loop_setup || ISSUE.cls.int_return
                        || ISSUE.cls.long_imm);

  // slot state: armed by a taken delayed branch, freed by the next issue
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= bcu_pkg::ST_RUN;
    end else if (fire) begin
      if (taken && delay && !slot_bad) begin
        state <= bcu_pkg::ST_SLOT;
      end else begin
        state <= bcu_pkg::ST_RUN;
      end
    end
  end

  // branch outcome towards fetch and pipeline control
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RESULT <= '0;
    end else begin
      RESULT.valid       <= fire;
      RESULT.taken       <= fire && taken && !slot_bad;
      RESULT.target      <= target;
      RESULT.kill_next   <= fire && taken && !delay && !slot_bad;
      RESULT.exec_slot   <= fire && taken && delay && !slot_bad;
      RESULT.kill_beyond <= fire && taken && !slot_bad;
      RESULT.seq_exc     <= fire && slot_bad;
    end
  end

  // branches leave the status flags alone
  always_ff @(posedge CLK) begin
    FLAG_WRITE <= 1'b0;
  end

  // observable history for software
  always_ff @(posedge CLK) begin
    if (RESET) begin
      taken_cnt  <= 32'h0;
      last_tgt   <= 32'h0;
      last_taken <= 1'b0;
    end else if (fire) begin
      last_taken <= taken && !slot_bad;
      if (taken && !slot_bad) begin
        taken_cnt <= taken_cnt + 32'h1;
        last_tgt  <= target;
      end
    end
  end

  // sticky exception flag; a new event wins over a clear
  always_ff @(posedge CLK) begin
    if (RESET) begin
      exc_sticky <= 1'b0;
    end else if (fire && slot_bad) begin
      exc_sticky <= 1'b1;
    end else if (exc_clr) begin
      exc_sticky <= 1'b0;
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic              aw_got;
  logic              w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              do_wr;
  logic              wr_hit;

  assign S_AXI_AWREADY = !aw_got && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_got && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign do_wr  = aw_got && w_got && !S_AXI_BVALID;
  assign wr_hit = aw_addr == ADDR_W'(`BCU_OFF_CTRL)
                  || aw_addr == ADDR_W'(`BCU_OFF_STATUS);
  assign exc_clr = do_wr && aw_addr == ADDR_W'(`BCU_OFF_STATUS)
                   && w_strb[0] && w_data[`BCU_STAT_EXC_BIT];

  // address and data are latched independently, in either order
  always_ff @(posedge CLK) begin
    if (RESET) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else if (do_wr) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got  <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got  <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
    end
  end

  // control register write
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl <= `BCU_CTRL_RESET;
    end else if (do_wr && aw_addr == ADDR_W'(`BCU_OFF_CTRL) && w_strb[0]) begin
      ctrl <= w_data[1:0];
    end
  end

  // write response
  always_ff @(posedge CLK) begin
    if (RESET) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `BCU_RESP_OKAY;
    end else if (do_wr) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_hit ? `BCU_RESP_OKAY : `BCU_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // read data path
  always_ff @(posedge CLK) begin
    if (RESET) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0;
      S_AXI_RRESP  <= `BCU_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= `BCU_RESP_OKAY;
      case (S_AXI_ARADDR)
        ADDR_W'(`BCU_OFF_CTRL):      S_AXI_RDATA <= {30'h0, ctrl};
        ADDR_W'(`BCU_OFF_STATUS):    S_AXI_RDATA <=
          {29'h0, exc_sticky, last_taken, state == bcu_pkg::ST_SLOT};
        ADDR_W'(`BCU_OFF_TAKEN_CNT): S_AXI_RDATA <= taken_cnt;
        ADDR_W'(`BCU_OFF_LAST_TGT):  S_AXI_RDATA <= last_tgt;
        default: begin
          S_AXI_RDATA <= 32'h0;
          S_AXI_RRESP <= `BCU_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  property p_bit_clear;
    fire && kind == bcu_pkg::BK_BIT_CLR && !slot_bad
      |=> RESULT.taken == !$past(test_bit);
  endproperty
  a_bit_clear: assert property (p_bit_clear)
    else $error("bit-clear branch outcome wrong");

  property p_bit_set;
    fire && kind == bcu_pkg::BK_BIT_SET && !slot_bad
      |=> RESULT.taken
          == $past(ISSUE.first_source_operand[ISSUE.second_source_operand[4:0]]);
  endproperty
  a_bit_set: assert property (p_bit_set)
    else $error("bit-set branch outcome wrong");

  property p_target;
    fire |=> RESULT.target ==
      ({$past(ISSUE.pc[31:2]), 2'b00} + $past(disp));
  endproperty
  a_target: assert property (p_target)
    else $error("target not word-aligned pc plus displacement");

  property p_flags;
    FLAG_WRITE == 1'b0;
  endproperty
  a_flags: assert property (p_flags)
    else $error("branch unit wrote flags");

  property p_nodelay_kill;
    fire && taken && !delay && !slot_bad
      |=> RESULT.kill_next && !RESULT.exec_slot && RESULT.kill_beyond;
  endproperty
  a_nodelay_kill: assert property (p_nodelay_kill)
    else $error("untaken-only slot not cancelled");

  property p_delay_slot;
    fire && taken && delay && !slot_bad
      |=> RESULT.exec_slot && !RESULT.kill_next
          && RESULT.kill_beyond && state == bcu_pkg::ST_SLOT;
  endproperty
  a_delay_slot: assert property (p_delay_slot)
    else $error("delayed branch slot handling wrong");

  property p_far;
    fire && kind == bcu_pkg::BK_FAR && !slot_bad |=> RESULT.taken;
  endproperty
  a_far: assert property (p_far)
    else $error("far branch not taken");

  property p_slot_exc;
    fire && slot_bad && ctrl[`BCU_CTRL_LATE_BIT]
      && state == bcu_pkg::ST_SLOT
      |=> RESULT.seq_exc && !RESULT.taken && exc_sticky;
  endproperty
  a_slot_exc: assert property (p_slot_exc)
    else $error("branch in delay slot not trapped");

  property p_not_taken;
    fire && !taken |=> !RESULT.taken && !RESULT.kill_beyond;
  endproperty
  a_not_taken: assert property (p_not_taken)
    else $error("untaken branch redirected");
endmodule : bcu_branch_unit
`default_nettype wire

/* File: testbench/bcu_fetch_model.sv */
// issue-side model that feeds the branch unit in order
`timescale 1ns/1ps
`default_nettype none
module bcu_fetch_model (
  input  wire logic           clk,   // core clock
  input  wire logic           reset, // sync reset, high
  input  wire logic           slow,  // idle cycle after each issue
  output logic                vld,   // instruction issued
  output bcu_pkg::bcu_issue_t iss,   // instruction and operands
  output logic                idle   // queue empty
);
  bcu_pkg::bcu_issue_t q[$]; // waiting instructions
  logic                gap;  // idle cycle owed

  // callers keep targets off slots and pcl out of sources
  task automatic push(input bcu_pkg::bcu_issue_t i);
    q.push_back(i);
  endtask : push

  // one issue per edge, bus scrambled between issues
  always @(posedge clk) begin
    if (reset) begin
      vld <= 1'b0;
      iss <= '0;
      gap <= 1'b0;
    end else if (q.size() != 0 && !gap) begin
      iss <= q.pop_front();
      vld <= 1'b1;
      gap <= slow;
    end else begin
      iss <= ~iss;
      vld <= 1'b0;
      gap <= 1'b0;
    end
    idle <= (q.size() == 0);
  end
endmodule : bcu_fetch_model
`default_nettype wire

/* File: testbench/branch_condition_unit_tb.sv */
// self-checking bench of the branch condition unit
`timescale 1ns/1ps
`default_nettype none
`include "bcu_regs.svh"
module branch_condition_unit_tb;
  // ****************
  // signals
  // ****************
  logic clk, reset, slow, vld, idle, fw;
  logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  logic [7:0]  aw_a, ar_a;
  logic [31:0] w_d, r_d, dv, last_tgt;
  logic [1:0]  b_resp, r_resp;
  logic [4:0]  q;
  logic [15:0] iw;
  int          n_errors, comparisons, n_taken, k, j;
  bcu_pkg::bcu_issue_t  iss, iss_d;
  bcu_pkg::bcu_result_t res;
  bcu_pkg::bcu_result_t exp_q[$];
  logic [4:0] smap [8] = '{`BCU_CC_GT, `BCU_CC_GE, `BCU_CC_LT,
    `BCU_CC_LE, `BCU_CC_HI, `BCU_CC_HS, `BCU_CC_LO, `BCU_CC_LS};

  bcu_fetch_model u_fetch (.clk(clk), .reset(reset), .slow(slow),
    .vld(vld), .iss(iss_d), .idle(idle));

  bcu_branch_unit #(.ADDR_W(8)) u_dut (.CLK(clk), .RESET(reset),
    .ISSUE_VALID(vld), .ISSUE(iss_d), .RESULT(res), .FLAG_WRITE(fw),
    .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_r),
    .S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w_v),
    .S_AXI_WREADY(w_r), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v),
    .S_AXI_BREADY(b_r), .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v),
    .S_AXI_ARREADY(ar_r), .S_AXI_RDATA(r_d), .S_AXI_RRESP(r_resp),
    .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r));

  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************
  // checks and helpers
  // ****************
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp_res(input bcu_pkg::bcu_result_t e,
                         input bcu_pkg::bcu_result_t g);
    comparisons++;
    if (!e.taken) g.target = e.target;
    if (g !== e) begin
      n_errors++;
      $display("unexpected result at %0t: exp %h got %h", $time, e, g);
    end
  endtask : cmp_res

  task automatic cmp32(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected value at %0t: exp %h got %h", $time, e, g);
    end
  endtask : cmp32

  // results are matched in issue order at mid-cycle
  always @(negedge clk) begin
    if (res.valid !== 1'b0) begin
      if (exp_q.size() == 0) cmp_res('0, res);
      else cmp_res(exp_q.pop_front(), res);
      cmp32(32'h0, {31'h0, fw});
    end
  end

  function automatic logic [31:0] sx(input logic [31:0] v, input int w);
    logic signed [31:0] t;
    t = v << (32 - w);
    return t >>> (32 - w);
  endfunction : sx

  function automatic logic cond(input logic [4:0] c,
                                input bcu_pkg::bcu_flags_t f);
    case (c)
      5'h00: return 1'b1;
      5'h01: return f.z;
      5'h02: return !f.z;
      5'h03: return !f.n;
      5'h04: return f.n;
      5'h05: return f.c;
      5'h06: return !f.c;
      5'h07: return f.v;
      5'h08: return !f.v;
      5'h09: return (f.n == f.v) && !f.z;
      5'h0a: return f.n == f.v;
      5'h0b: return f.n != f.v;
      5'h0c: return f.z || (f.n != f.v);
      5'h0d: return !f.c && !f.z;
      5'h0e: return f.c || f.z;
      5'h0f: return !f.n && !f.z;
      default: return 1'b0;
    endcase
  endfunction : cond

  function automatic logic [31:0] bbit(input logic s, input logic d);
    return {`BCU_MAJ_BBIT, 3'h0, dv[7:1], 1'b1, dv[8], 9'h0, d, 1'b0,
            s ? `BCU_BBIT_SET : `BCU_BBIT_CLR};
  endfunction : bbit

  task automatic rnd();
    iss.pc = $urandom & 32'hfffffffe;
    iss.first_source_operand = $urandom;
    iss.second_source_operand = $urandom;
    iss.flags = 4'($urandom);
    iss.cls = '0;
  endtask : rnd

  // queue a branch and note its outcome
  task automatic br(input logic [31:0] i, input logic s16,
                    input logic tk, input logic d);
    logic [31:0] t;
    t = {iss.pc[31:2], 2'b00} + dv;
    iss.insn = i;
    iss.is16 = s16;
    if (tk) n_taken++;
    if (tk) last_tgt = t;
    u_fetch.push(iss);
    exp_q.push_back('{1'b1, tk, t, tk & !d, tk, tk & d, 1'b0});
  endtask : br

  task automatic slot(input logic [3:0] c, input logic x);
    iss.insn = 32'h20000000;
    iss.is16 = 1'b0;
    iss.cls = c;
    u_fetch.push(iss);
    exp_q.push_back('{1'b1, 1'b0, 32'h0, 1'b0, 1'b0, 1'b0, x});
  endtask : slot

  task automatic drain();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(idle && exp_q.size() == 0) && n < 300);
    if (n >= 300) n_errors++;
    if (n >= 300) report_and_stop();
    repeat (3) @(posedge clk);
  endtask : drain

  // register write; address and data released as each is taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    logic aw, w, b;
    int   n;
    b = 1'b0;
    @(posedge clk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    for (n = 0; n < 50 && !b; n++) begin
      @(negedge clk);
      aw = aw_v & aw_r;
      w = w_v & w_r;
      b = b_v === 1'b1;
      if (b) cmp32({30'h0, r}, {30'h0, b_resp});
      @(posedge clk);
      if (aw) aw_v <= 1'b0;
      if (w) w_v <= 1'b0;
      if (b) b_r <= 1'b0;
    end
    if (!b) n_errors++;
    if (!b) report_and_stop();
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    logic ar, rv;
    int   n;
    rv = 1'b0;
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    for (n = 0; n < 50 && !rv; n++) begin
      @(negedge clk);
      ar = ar_v & ar_r;
      rv = r_v === 1'b1;
      if (rv) cmp32(d, r_d);
      if (rv) cmp32({30'h0, r}, {30'h0, r_resp});
      @(posedge clk);
      if (ar) ar_v <= 1'b0;
      if (rv) r_r <= 1'b0;
    end
    if (!rv) n_errors++;
    if (!rv) report_and_stop();
  endtask : axi_rd

  // ****************
  // main sequence
  // ****************
  initial begin
    void'($urandom(73));
    {reset, slow, aw_v, w_v, b_r, ar_v, r_r} = 7'h40;
    {aw_a, ar_a, w_d, n_taken, n_errors, comparisons} = '0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    axi_rd(`BCU_OFF_CTRL, 32'h1, `BCU_RESP_OKAY);
    axi_rd(8'h10, 32'h0, `BCU_RESP_SLVERR);
    axi_wr(8'h10, 32'h0, `BCU_RESP_SLVERR);
    slow <= 1'b1;
    for (k = 0; k < 40; k++) begin
      rnd();
      dv = sx($urandom & 32'h1fe, 9);
      br(bbit(k[0], 1'b0), 1'b0, iss.first_source_operand[iss.second_source_operand[4:0]] == k[0],
         1'b0);
    end
    drain();
    slow <= 1'b0;
    for (k = 0; k < 64; k++) begin
      rnd();
      q = k[4:0];
      dv = sx($urandom & 32'h1ffffe, 21);
      br({5'h0, dv[10:1], 1'b0, dv[20:11], 1'b0, q}, 1'b0,
         cond(q, iss.flags), 1'b0);
    end
    for (k = 0; k < 4; k++) begin
      rnd();
      dv = k[0] ? 32'hff000000 : sx($urandom & 32'h1fffffe, 25);
      // always-taken far branches lean to negative reach
      br({5'h0, dv[10:1], 1'b1, dv[20:11], 2'b0, dv[24:21]}, 1'b0, 1'b1,
         1'b0);
    end
    for (k = 0; k < 30; k++) begin
      rnd();
      j = k % 10;
      dv = (j < 2) ? sx($urandom & 32'h3fe, 10) : sx($urandom & 32'h7e, 7);
      q = (j < 2) ? (j ? `BCU_CC_NE : `BCU_CC_EQ) : smap[j - 2];
      iw = {`BCU_S_BCC, 3'(j - 2), dv[6:1]};
      if (j < 2) iw = {j ? `BCU_S_BNE : `BCU_S_BEQ, dv[9:1]};
      br({16'h0, iw}, 1'b1, cond(q, iss.flags), 1'b0);
    end
    for (k = 0; k < 4; k++) begin
      rnd();
      iss.first_source_operand[iss.second_source_operand[4:0]] = k[0];
      dv = sx($urandom & 32'h1fe, 9);
      br(bbit(k[0], 1'b1), 1'b0, 1'b1, 1'b1);
      slot(4'(1 << k), 1'b0);
    end
    drain();
    axi_wr(`BCU_OFF_CTRL, 32'h3, `BCU_RESP_OKAY);
    for (k = 0; k < 5; k++) begin
      rnd();
      dv = sx($urandom & 32'h1ffffe, 21);
      br({5'h0, dv[10:1], 1'b0, dv[20:11], 1'b1, 5'h0}, 1'b0, 1'b1,
         1'b1);
      slot(4'(1 << k), k < 4);
    end
    drain();
    axi_rd(`BCU_OFF_STATUS, 32'h4, `BCU_RESP_OKAY);
    axi_wr(`BCU_OFF_STATUS, 32'h4, `BCU_RESP_OKAY);
    axi_rd(`BCU_OFF_STATUS, 32'h0, `BCU_RESP_OKAY);
    axi_wr(`BCU_OFF_CTRL, 32'h0, `BCU_RESP_OKAY);
    rnd();
    iss.insn = 32'h0;
    u_fetch.push(iss);
    drain();
    axi_wr(`BCU_OFF_CTRL, 32'h1, `BCU_RESP_OKAY);
    axi_rd(`BCU_OFF_TAKEN_CNT, n_taken, `BCU_RESP_OKAY);
    axi_rd(`BCU_OFF_LAST_TGT, last_tgt, `BCU_RESP_OKAY);
    report_and_stop();
  end
endmodule : branch_condition_unit_tb
`default_nettype wire
